/* File: design/lcr_ctrl.sv */
// Control registers of a dot-matrix LCD driver: column pointer, segment order,
// static drive, duty select and status byte, decoded from the 8-bit host bus.
// Assumes bus inputs synchronous to CLOCK_I and BUS_STROBE_I one cycle per access.
`timescale 1ns/1ns
`include "lcr_defs.svh"

module lcr_ctrl #(
  parameter bit SEGMENT_ONLY = 1'b0
) (
  input  wire logic                      CLOCK_I,
  input  wire logic                      RST_N_I,
  input  wire logic                      BUS_STROBE_I,
  input  wire logic                      CMD_DATA_SELECT_I,
  input  wire logic                      READ_ENABLE_STROBE_I,
  input  wire logic                      READ_WRITE_SELECT_I,
  input  wire logic [7:0]                DATA_I,
  output logic      [7:0]                DATA_O,
  output logic                           DATA_OE_N_O,
  input  wire logic                      DISPLAY_ON_I,
  input  wire logic [`LCR_SEG_COUNT-1:0] COLUMN_DATA_I,
  output logic      [`LCR_SEG_COUNT-1:0] SEGMENT_DATA_O,
  output logic      [6:0]                COLUMN_POINTER_O,
  output logic                           SEG_ORDER_REVERSED_O,
  output logic                           DUTY_32_O,
  output logic                           EXTERNAL_SCAN_O,
  output logic                           STATIC_DRIVE_O,
  output logic                           INT_CLOCK_EN_O,
  output logic                           FORCE_SUPPLY_O,
  output logic                           OSC_OUT_OE_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  lcr_pkg::lcr_bus_s    bus;
  lcr_pkg::lcr_state_e  state_reg;
  lcr_pkg::lcr_state_e  state_next;
  lcr_pkg::lcr_status_s status;
  logic [3:0]           count_reg;
  logic [3:0]           count_next;
  logic [6:0]           column_reg;
  logic [6:0]           column_save_reg;
  logic                 mapping_reg;
  logic                 static_reg;
  logic                 duty_reg;
  logic                 rmw_reg;
  logic                 low_power;
  logic                 ready;
  logic                 cmd_write;
  logic                 data_write;
  logic                 data_read;
  logic                 status_read;
  logic                 data_access;
  logic                 op_mapping;
  logic                 op_static;
  logic                 op_duty;
  logic                 op_column;
  logic                 op_rmw_start;
  logic                 op_rmw_end;
  logic [7:0]           data_reg;
  logic                 oe_n_reg;
  logic [`LCR_SEG_COUNT-1:0] seg_reg;

  assign bus = '{cmd_data_select:    CMD_DATA_SELECT_I,
                 read_enable_strobe: READ_ENABLE_STROBE_I,
                 read_write_select:  READ_WRITE_SELECT_I,
                 data:               DATA_I};

  assign ready = (state_reg == lcr_pkg::LCR_ST_READY);

  // Writes and data reads that arrive while busy or resetting are dropped; status reads are always taken; host polls busy
  assign cmd_write   = BUS_STROBE_I && ready && !bus.cmd_data_select
                       && bus.read_enable_strobe && !bus.read_write_select;
  assign data_write  = BUS_STROBE_I && ready && bus.cmd_data_select
                       && !bus.read_write_select;
  assign data_read   = BUS_STROBE_I && ready && bus.cmd_data_select
                       && !bus.read_enable_strobe && bus.read_write_select;
  assign status_read = BUS_STROBE_I && !bus.cmd_data_select
                       && !bus.read_enable_strobe && bus.read_write_select;
  assign data_access = data_write || (data_read && !rmw_reg);

  // Fixed upper-bit or whole-byte patterns; anything else falls through untouched
  assign op_column    = cmd_write && !bus.data[`LCR_LOAD_BIT];
  assign op_mapping   = cmd_write && (bus.data[7:1] == `LCR_OP_MAPPING);
  assign op_static    = cmd_write && (bus.data[7:1] == `LCR_OP_STATIC);
  assign op_duty      = cmd_write && (bus.data[7:1] == `LCR_OP_DUTY);
  assign op_rmw_start = cmd_write && (bus.data == `LCR_OP_RMW_START);
  assign op_rmw_end   = cmd_write && (bus.data == `LCR_OP_RMW_END);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and busy sequencing

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      lcr_pkg::LCR_ST_RESET: begin
        count_next = count_reg - 4'h1;
        if (count_reg == 4'h1) begin
          state_next = lcr_pkg::LCR_ST_READY;
        end
      end
      lcr_pkg::LCR_ST_READY: begin
        if (cmd_write || data_write || data_read) begin
          state_next = lcr_pkg::LCR_ST_BUSY;
          count_next = `LCR_BUSY_CYCLES;
        end
      end
      lcr_pkg::LCR_ST_BUSY: begin
        count_next = count_reg - 4'h1;
        if (count_reg == 4'h1) begin
          state_next = lcr_pkg::LCR_ST_READY;
        end
      end
      default: begin
        state_next = lcr_pkg::LCR_ST_RESET;
        count_next = `LCR_RESET_CYCLES;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= lcr_pkg::LCR_ST_RESET;
      count_reg <= `LCR_RESET_CYCLES;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column pointer and read-modify-write

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      column_reg <= `LCR_COL_RESET;
    end else if (op_column && !rmw_reg) begin
      column_reg <= bus.data[6:0];
    end else if (op_rmw_end && rmw_reg) begin
      column_reg <= column_save_reg;
    end else if (data_access) begin
      if (column_reg >= `LCR_COL_LAST) begin
        column_reg <= `LCR_COL_RESET;
      end else begin
        column_reg <= column_reg + 7'h01;
      end
    end
  end

  // Saved pointer is restored when the mode ends
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rmw_reg         <= 1'b0;
      column_save_reg <= `LCR_COL_RESET;
    end else if (op_rmw_start) begin
      rmw_reg         <= 1'b1;
      column_save_reg <= column_reg;
    end else if (op_rmw_end) begin
      rmw_reg         <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-bit settings

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mapping_reg <= 1'b0;
    end else if (op_mapping) begin
      mapping_reg <= bus.data[`LCR_VALUE_BIT];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      static_reg <= 1'b0;
    end else if (op_static) begin
      static_reg <= bus.data[`LCR_VALUE_BIT];
    end
  end

  // Segment-only parts have no duty setting at all
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      duty_reg <= 1'b0;
    end else if (op_duty && !SEGMENT_ONLY) begin
      duty_reg <= bus.data[`LCR_VALUE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment mapping, frozen while static drive is on

  assign low_power = static_reg && !DISPLAY_ON_I;

  genvar seg;
  generate
    for (seg = 0; seg < `LCR_SEG_COUNT; seg = seg + 1) begin : g_seg
      always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          seg_reg[seg] <= 1'b0;
        end else if (!static_reg) begin
          seg_reg[seg] <= mapping_reg ? COLUMN_DATA_I[`LCR_SEG_COUNT-1-seg]
                                      : COLUMN_DATA_I[seg];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status read

  assign status = '{busy:        !ready,
                    mapping:     mapping_reg,
                    display_off: !DISPLAY_ON_I,
                    resetting:   (state_reg == lcr_pkg::LCR_ST_RESET),
                    zero:        `LCR_STAT_LOW};

  // Drives the bus for one cycle after the status strobe
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      data_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= !status_read;
      if (status_read) begin
        data_reg <= status;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DATA_O               = data_reg;
  assign DATA_OE_N_O          = oe_n_reg;
  assign SEGMENT_DATA_O       = seg_reg;
  assign COLUMN_POINTER_O     = column_reg;
  assign SEG_ORDER_REVERSED_O = mapping_reg;
  assign DUTY_32_O            = duty_reg;
  assign EXTERNAL_SCAN_O      = SEGMENT_ONLY;
  assign STATIC_DRIVE_O       = static_reg;
  assign INT_CLOCK_EN_O       = !static_reg;
  assign FORCE_SUPPLY_O       = low_power;
  assign OSC_OUT_OE_N_O       = low_power;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_col_increment: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    data_write && !op_column && column_reg < `LCR_COL_LAST |=> column_reg == $past(column_reg) + 7'h01)
    else $error("column pointer did not advance");

  a_col_wrap: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    data_access && column_reg == `LCR_COL_LAST |=> column_reg == `LCR_COL_RESET)
    else $error("column pointer did not wrap");

  a_col_load: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    op_column && !rmw_reg |=> column_reg == $past(DATA_I[6:0]))
    else $error("column pointer load wrong");

  a_rmw_read_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    data_read && rmw_reg |=> $stable(column_reg))
    else $error("column moved on read in rmw mode");

  a_mapping_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    op_mapping |=> SEG_ORDER_REVERSED_O == $past(DATA_I[0]) ##1 $stable(SEG_ORDER_REVERSED_O))
    else $error("mapping setting wrong");

  a_static_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    op_static |=> STATIC_DRIVE_O == $past(DATA_I[0]) && INT_CLOCK_EN_O == !$past(DATA_I[0]))
    else $error("static drive setting wrong");

  a_duty_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    op_duty && !SEGMENT_ONLY |=> DUTY_32_O == $past(DATA_I[0]))
    else $error("duty setting wrong");

  a_seg_reverse: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    mapping_reg && !static_reg |=> SEGMENT_DATA_O[0] == $past(COLUMN_DATA_I[`LCR_SEG_COUNT-1]))
    else $error("reversed segment order wrong");

  a_static_freeze: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    static_reg |=> $stable(SEGMENT_DATA_O))
    else $error("segment data moved in static drive");

  a_low_power_pins: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    STATIC_DRIVE_O && !DISPLAY_ON_I |-> FORCE_SUPPLY_O && OSC_OUT_OE_N_O && !INT_CLOCK_EN_O)
    else $error("low-power pins wrong");

  a_status_byte: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    status_read |=> !DATA_OE_N_O && DATA_O[3:0] == 4'h0 && DATA_O[6] == $past(mapping_reg))
    else $error("status byte wrong");

  a_status_flags: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    status_read |=> DATA_O[7] == !$past(ready) && DATA_O[5] == !$past(DISPLAY_ON_I)
                    && DATA_O[4] == ($past(state_reg) == lcr_pkg::LCR_ST_RESET))
    else $error("status flags wrong");

  a_busy_after_write: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    cmd_write |=> !ready [*2] ##1 ready)
    else $error("busy window wrong");

endmodule : lcr_ctrl

/* File: inc/lcr_defs.svh */
// Constants for the LCD driver control block: command codes, field positions, counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

`define LCR_COL_LAST      7'h4F
`define LCR_COL_RESET     7'h00
`define LCR_OP_MAPPING    7'h50
`define LCR_OP_STATIC     7'h52
`define LCR_OP_DUTY       7'h54
`define LCR_OP_RMW_START  8'hE0
`define LCR_OP_RMW_END    8'hEE
`define LCR_LOAD_BIT      7
`define LCR_VALUE_BIT     0
`define LCR_STAT_LOW      4'h0
`define LCR_RESET_CYCLES  4'h8
`define LCR_BUSY_CYCLES   4'h2
`define LCR_SEG_COUNT     80

`endif

/* File: inc/lcr_pkg.sv */
// Types shared by the LCD driver control block.
// Assumes lcr_defs.svh is reachable on the include path.
`include "lcr_defs.svh"

package lcr_pkg;

  typedef enum logic [2:0] {
    LCR_ST_RESET = 3'b001,
    LCR_ST_READY = 3'b010,
    LCR_ST_BUSY  = 3'b100
  } lcr_state_e;

  typedef struct packed {
    logic       cmd_data_select;
    logic       read_enable_strobe;
    logic       read_write_select;
    logic [7:0] data;
  } lcr_bus_s;

  typedef struct packed {
    logic       busy;
    logic       mapping;
    logic       display_off;
    logic       resetting;
    logic [3:0] zero;
  } lcr_status_s;

endpackage : lcr_pkg

/* File: verification/lcr_host_model.sv */
// Host microcontroller model on the 8-bit parallel bus of the control block.
// Assumes the caller runs one access at a time; signals change on falling edges only.
`timescale 1ns/1ns

module lcr_host_model (
  input  wire logic        clock_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        data_oe_n_i,
  output logic             strobe_o,
  output logic             power_save_o,
  output lcr_pkg::lcr_bus_s bus_o
);

  initial begin
    strobe_o = 1'h0;
    power_save_o = 1'h0;
    bus_o    = {1'h0, 1'h1, 1'h1, 8'h5A};
  end

  // Bias cut line, raised by the host around the low-power state
  task automatic set_power_save(input logic v);
    @(negedge clock_i);
    power_save_o = v;
  endtask : set_power_save

  ////////////////////////////////////////////////////////////////////////////
  // One access: held across the taking edge, answer sampled one cycle later
  task automatic access(input logic cd, input logic rd, input logic rw, input logic [7:0] d,
                        output logic [7:0] q, output logic oe_n);
    @(negedge clock_i);
    strobe_o = 1'h1;
    bus_o    = {cd, rd, rw, d};
    @(negedge clock_i);
    q        = data_i;
    oe_n     = data_oe_n_i;
    strobe_o = 1'h0;
    // Released lines show the inverse so a stale byte never looks valid
    bus_o    = {1'h0, 1'h1, 1'h1, ~d};
  endtask : access

endmodule : lcr_host_model

/* File: verification/lcr_ctrl_tb.sv */
// Self-checking bench for the LCD driver control block.
// Assumes lcr_host_model drives the bus; display state and column data come from here.
`timescale 1ns/1ns

module lcr_ctrl_tb;
  logic              clock;
  logic              rst_n;
  logic              display_on;
  logic [79:0]       column_data;
  logic              strobe;
  lcr_pkg::lcr_bus_s bus;
  logic [7:0]        data_out;
  logic              oe_n;
  logic [79:0]       seg;
  logic [6:0]        col;
  logic              rev;
  logic              duty;
  logic              ext_scan;
  logic              static_on;
  logic              clk_en;
  logic              force_sup;
  logic              osc_oe_n;
  logic              power_save;
  logic [7:0]        st;
  int                err_total;
  int                check_count;

  lcr_ctrl lcr_ctrl_inst (
    .CLOCK_I(clock), .RST_N_I(rst_n), .BUS_STROBE_I(strobe),
    .CMD_DATA_SELECT_I(bus.cmd_data_select), .READ_ENABLE_STROBE_I(bus.read_enable_strobe),
    .READ_WRITE_SELECT_I(bus.read_write_select), .DATA_I(bus.data), .DATA_O(data_out),
    .DATA_OE_N_O(oe_n), .DISPLAY_ON_I(display_on), .COLUMN_DATA_I(column_data),
    .SEGMENT_DATA_O(seg), .COLUMN_POINTER_O(col), .SEG_ORDER_REVERSED_O(rev), .DUTY_32_O(duty),
    .EXTERNAL_SCAN_O(ext_scan), .STATIC_DRIVE_O(static_on), .INT_CLOCK_EN_O(clk_en),
    .FORCE_SUPPLY_O(force_sup), .OSC_OUT_OE_N_O(osc_oe_n)
  );

  lcr_host_model lcr_host_model_inst (
    .clock_i(clock), .data_i(data_out), .data_oe_n_i(oe_n), .strobe_o(strobe),
    .power_save_o(power_save), .bus_o(bus)
  );

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_status(output logic [7:0] s);
    logic o;
    lcr_host_model_inst.access(1'h0, 1'h0, 1'h1, 8'h00, s, o);
    chk({79'h0, o}, 80'h0);
  endtask : rd_status

  // Bounded busy poll; running out ends the run
  task automatic wait_ready();
    logic [7:0] s;
    for (int n = 0; n < 20; n++) begin
      rd_status(s);
      if (s[7] === 1'h0) return;
    end
    err_total++;
    close_out();
  endtask : wait_ready

  task automatic put(input logic cd, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    wait_ready();
    lcr_host_model_inst.access(cd, 1'h1, 1'h0, d, q, o);
  endtask : put

  task automatic get_data();
    logic [7:0] q;
    logic       o;
    wait_ready();
    lcr_host_model_inst.access(1'h1, 1'h0, 1'h1, 8'h00, q, o);
  endtask : get_data

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    logic       o;
    clock = 1'h0;
    rst_n = 1'h0;
    display_on = 1'h1;
    column_data = 80'h1;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    @(negedge clock) rst_n = 1'h1;
    rd_status(st);
    chk(st, 8'h90);
    wait_ready();
    rd_status(st);
    chk(st, 8'h00);
    put(1'h0, 8'h4E);
    chk(col, 7'h4E);
    put(1'h1, 8'h5A);
    chk(col, 7'h4F);
    put(1'h1, 8'h00);
    chk(col, 7'h00);
    get_data();
    chk(col, 7'h01);
    put(1'h0, 8'hA1);
    chk(rev, 1'h1);
    repeat (2) @(negedge clock);
    chk(seg, 80'h8000_0000_0000_0000_0000);
    wait_ready();
    rd_status(st);
    chk(st, 8'h40);
    put(1'h0, 8'hA0);
    repeat (2) @(negedge clock);
    chk(seg, 80'h1);
    put(1'h0, 8'hA9);
    chk(duty, 1'h1);
    put(1'h0, 8'hA8);
    chk(duty, 1'h0);
    chk(ext_scan, 1'h0);
    put(1'h0, 8'hA9);
    put(1'h0, 8'hA2);
    put(1'h0, 8'hA6);
    chk({rev, duty, static_on, col}, {3'h2, 7'h01});
    display_on = 1'h0;
    wait_ready();
    rd_status(st);
    chk(st, 8'h20);
    put(1'h0, 8'hA5);
    chk({static_on, clk_en, force_sup, osc_oe_n}, 4'hB);
    lcr_host_model_inst.set_power_save(1'h1);
    chk({power_save, force_sup}, 2'h3);
    column_data = 80'hF0;
    repeat (3) @(negedge clock);
    chk(seg, 80'h1);
    chk({duty, col}, {1'h1, 7'h01});
    lcr_host_model_inst.set_power_save(1'h0);
    put(1'h0, 8'hA4);
    chk({static_on, clk_en, force_sup, osc_oe_n}, 4'h4);
    repeat (2) @(negedge clock);
    chk(seg, 80'hF0);
    display_on = 1'h1;
    put(1'h0, 8'hE0);
    put(1'h0, 8'h10);
    chk(col, 7'h01);
    get_data();
    chk(col, 7'h01);
    put(1'h1, 8'h33);
    chk(col, 7'h02);
    put(1'h0, 8'hEE);
    chk(col, 7'h01);
    // Second write lands inside the busy window and must be dropped
    put(1'h0, 8'h20);
    lcr_host_model_inst.access(1'h0, 1'h1, 1'h0, 8'h30, q, o);
    chk(col, 7'h20);
    close_out();
  end

endmodule : lcr_ctrl_tb
